// ==== logic/reset_irq_vector_placement.sv ====
// reset and interrupt vector address generator
// assumes the core pulses i_take when it accepts o_vec and fetches from it
//
// Functional notes
// - slot spacing one or two words per variant
// - fuse zero gives boot reset address only from the first clock after reset
// - table select adds boot start to vectors
// - vector one base 0x000 when fuse is one, and for either fuse until the first clock after reset
// - external irq zero, one at 0x001, 0x002
// - pin change requests at 0x003 to 0x005
// - watchdog time-out vectors to 0x006
// - timer two sources at 0x007 to 0x009
// - timer one sources at 0x00A to 0x00D
// - timer zero sources at 0x00E to 0x010
// - serial peripheral done at 0x011
// - usart sources at 0x012 to 0x014
// - adc to store-done at 0x015 to 0x019
// - vector issued only for enabled pending request
// - taking watchdog vector clears flag unless a time-out comes in the same cycle, and clears enable when reset enable is set
`timescale 1ns/1ps
module reset_irq_vector_placement
  import vec_place_pkg::*;
#(
  parameter int WORDS_PER_SLOT = 1,
  parameter logic [PC_W-1:0] BOOT_START = BOOT_START_DEF
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_boot_reset_select_fuse,
  input wire logic i_vector_table_select,
  input wire logic i_global_int_enable,
  input wire logic [NUM_SRC-1:0] i_irq_req,
  input wire logic [NUM_SRC-1:0] i_irq_en,
  input wire logic i_take,
  input wire logic i_watchdog_timeout,
  input wire logic i_watchdog_int_flag_clear,
  input wire logic i_watchdog_int_enable_set,
  input wire logic i_watchdog_int_enable_clear,
  input wire logic i_watchdog_reset_enable,
  output logic [PC_W-1:0] o_reset_addr,
  output vec_req_t o_vec,
  output logic o_watchdog_int_flag,
  output logic o_watchdog_int_enable
);

  typedef struct packed {
    logic [PC_W-1:0] reset_addr;
    vec_req_t vec;
    wdt_bits_t wdt;
  } state_t;

  state_t cur;
  state_t next_cur;

  // base-table slot of a zero-based source, before spacing
  function automatic logic [PC_W-1:0] base_of(input logic [4:0] idx);
    case (idx)
      // external requests
      SRC_EXT_IRQ_ZERO: begin
        base_of = BASE_EXT_IRQ_ZERO;
      end
      SRC_EXT_IRQ_ONE: begin
        base_of = BASE_EXT_IRQ_ONE;
      end

      // pin change requests
      SRC_PIN_CHANGE_REQ_ZERO: begin
        base_of = BASE_PIN_CHANGE_REQ_ZERO;
      end
      SRC_PIN_CHANGE_REQ_ONE: begin
        base_of = BASE_PIN_CHANGE_REQ_ONE;
      end
      SRC_PIN_CHANGE_REQ_TWO: begin
        base_of = BASE_PIN_CHANGE_REQ_TWO;
      end

      // watchdog time-out
      WDT_SRC_IDX: begin
        base_of = BASE_WDT;
      end

      // timer two
      SRC_TMR2_CMP_A: begin
        base_of = BASE_TMR2_CMP_A;
      end
      SRC_TMR2_CMP_B: begin
        base_of = BASE_TMR2_CMP_B;
      end
      SRC_TMR2_OVF: begin
        base_of = BASE_TMR2_OVF;
      end

      // timer one
      SRC_TMR1_CAPTURE: begin
        base_of = BASE_TMR1_CAPTURE;
      end
      SRC_TMR1_CMP_A: begin
        base_of = BASE_TMR1_CMP_A;
      end
      SRC_TMR1_CMP_B: begin
        base_of = BASE_TMR1_CMP_B;
      end
      SRC_TMR1_OVF: begin
        base_of = BASE_TMR1_OVF;
      end

      // timer zero
      SRC_TMR0_CMP_A: begin
        base_of = BASE_TMR0_CMP_A;
      end
      SRC_TMR0_CMP_B: begin
        base_of = BASE_TMR0_CMP_B;
      end
      SRC_TMR0_OVF: begin
        base_of = BASE_TMR0_OVF;
      end

      // serial peripheral
      SRC_SPI_DONE: begin
        base_of = BASE_SPI_DONE;
      end

      // usart
      SRC_USART_RX_DONE: begin
        base_of = BASE_USART_RX_DONE;
      end
      SRC_TX_BUFFER_EMPTY: begin
        base_of = BASE_TX_BUFFER_EMPTY;
      end
      SRC_USART_TX_DONE: begin
        base_of = BASE_USART_TX_DONE;
      end

      // converter, eeprom, comparator, two-wire, store
      SRC_ADC_DONE: begin
        base_of = BASE_ADC_DONE;
      end
      SRC_EEPROM_WRITE_DONE: begin
        base_of = BASE_EEPROM_WRITE_DONE;
      end
      SRC_ANALOG_COMP: begin
        base_of = BASE_ANALOG_COMP;
      end
      SRC_TWO_WIRE_SERIAL_UNIT: begin
        base_of = BASE_TWO_WIRE_SERIAL_UNIT;
      end
      SRC_SELF_PROGRAM_STORE_DONE: begin
        base_of = BASE_SELF_PROGRAM_STORE_DONE;
      end
      default: begin
        base_of = '0;
      end
    endcase
  endfunction

  // first pending source in vector order
  function automatic logic [4:0] lowest_pending(input logic [NUM_SRC-1:0] p);
    if (p[SRC_EXT_IRQ_ZERO]) begin
      lowest_pending = SRC_EXT_IRQ_ZERO;
    end else if (p[SRC_EXT_IRQ_ONE]) begin
      lowest_pending = SRC_EXT_IRQ_ONE;
    end else if (p[SRC_PIN_CHANGE_REQ_ZERO]) begin
      lowest_pending = SRC_PIN_CHANGE_REQ_ZERO;
    end else if (p[SRC_PIN_CHANGE_REQ_ONE]) begin
      lowest_pending = SRC_PIN_CHANGE_REQ_ONE;
    end else if (p[SRC_PIN_CHANGE_REQ_TWO]) begin
      lowest_pending = SRC_PIN_CHANGE_REQ_TWO;
    end else if (p[WDT_SRC_IDX]) begin
      lowest_pending = WDT_SRC_IDX;
    end else if (p[SRC_TMR2_CMP_A]) begin
      lowest_pending = SRC_TMR2_CMP_A;
    end else if (p[SRC_TMR2_CMP_B]) begin
      lowest_pending = SRC_TMR2_CMP_B;
    end else if (p[SRC_TMR2_OVF]) begin
      lowest_pending = SRC_TMR2_OVF;
    end else if (p[SRC_TMR1_CAPTURE]) begin
      lowest_pending = SRC_TMR1_CAPTURE;
    end else if (p[SRC_TMR1_CMP_A]) begin
      lowest_pending = SRC_TMR1_CMP_A;
    end else if (p[SRC_TMR1_CMP_B]) begin
      lowest_pending = SRC_TMR1_CMP_B;
    end else if (p[SRC_TMR1_OVF]) begin
      lowest_pending = SRC_TMR1_OVF;
    end else if (p[SRC_TMR0_CMP_A]) begin
      lowest_pending = SRC_TMR0_CMP_A;
    end else if (p[SRC_TMR0_CMP_B]) begin
      lowest_pending = SRC_TMR0_CMP_B;
    end else if (p[SRC_TMR0_OVF]) begin
      lowest_pending = SRC_TMR0_OVF;
    end else if (p[SRC_SPI_DONE]) begin
      lowest_pending = SRC_SPI_DONE;
    end else if (p[SRC_USART_RX_DONE]) begin
      lowest_pending = SRC_USART_RX_DONE;
    end else if (p[SRC_TX_BUFFER_EMPTY]) begin
      lowest_pending = SRC_TX_BUFFER_EMPTY;
    end else if (p[SRC_USART_TX_DONE]) begin
      lowest_pending = SRC_USART_TX_DONE;
    end else if (p[SRC_ADC_DONE]) begin
      lowest_pending = SRC_ADC_DONE;
    end else if (p[SRC_EEPROM_WRITE_DONE]) begin
      lowest_pending = SRC_EEPROM_WRITE_DONE;
    end else if (p[SRC_ANALOG_COMP]) begin
      lowest_pending = SRC_ANALOG_COMP;
    end else if (p[SRC_TWO_WIRE_SERIAL_UNIT]) begin
      lowest_pending = SRC_TWO_WIRE_SERIAL_UNIT;
    end else if (p[SRC_SELF_PROGRAM_STORE_DONE]) begin
      lowest_pending = SRC_SELF_PROGRAM_STORE_DONE;
    end else begin
      lowest_pending = SRC_NONE;
    end
  endfunction

  // slot address for a zero-based source index
  function automatic logic [PC_W-1:0] slot_addr(input logic [4:0] idx,
                                                 input logic sel);
    logic [PC_W-1:0] base;
    base = PC_W'(32'(base_of(idx)) * WORDS_PER_SLOT);
    slot_addr = sel ? PC_W'(base + BOOT_START) : base;
  endfunction

  logic [NUM_SRC-1:0] req_en;
  logic [NUM_SRC-1:0] pending;
  logic [4:0] winner;

  always_comb begin
    req_en = i_irq_req & i_irq_en;
    pending = '0;
    pending[SRC_EXT_IRQ_ZERO] = req_en[SRC_EXT_IRQ_ZERO];
    pending[SRC_EXT_IRQ_ONE] = req_en[SRC_EXT_IRQ_ONE];

    pending[SRC_PIN_CHANGE_REQ_ZERO] = req_en[SRC_PIN_CHANGE_REQ_ZERO];
    pending[SRC_PIN_CHANGE_REQ_ONE] = req_en[SRC_PIN_CHANGE_REQ_ONE];
    pending[SRC_PIN_CHANGE_REQ_TWO] = req_en[SRC_PIN_CHANGE_REQ_TWO];

    // watchdog request comes from its own flag, not the request word
    pending[WDT_SRC_IDX] = cur.wdt.watchdog_int_flag & cur.wdt.watchdog_int_enable;

    pending[SRC_TMR2_CMP_A] = req_en[SRC_TMR2_CMP_A];
    pending[SRC_TMR2_CMP_B] = req_en[SRC_TMR2_CMP_B];
    pending[SRC_TMR2_OVF] = req_en[SRC_TMR2_OVF];

    pending[SRC_TMR1_CAPTURE] = req_en[SRC_TMR1_CAPTURE];
    pending[SRC_TMR1_CMP_A] = req_en[SRC_TMR1_CMP_A];
    pending[SRC_TMR1_CMP_B] = req_en[SRC_TMR1_CMP_B];
    pending[SRC_TMR1_OVF] = req_en[SRC_TMR1_OVF];

    pending[SRC_TMR0_CMP_A] = req_en[SRC_TMR0_CMP_A];
    pending[SRC_TMR0_CMP_B] = req_en[SRC_TMR0_CMP_B];
    pending[SRC_TMR0_OVF] = req_en[SRC_TMR0_OVF];

    pending[SRC_SPI_DONE] = req_en[SRC_SPI_DONE];

    pending[SRC_USART_RX_DONE] = req_en[SRC_USART_RX_DONE];
    pending[SRC_TX_BUFFER_EMPTY] = req_en[SRC_TX_BUFFER_EMPTY];
    pending[SRC_USART_TX_DONE] = req_en[SRC_USART_TX_DONE];

    pending[SRC_ADC_DONE] = req_en[SRC_ADC_DONE];
    pending[SRC_EEPROM_WRITE_DONE] = req_en[SRC_EEPROM_WRITE_DONE];
    pending[SRC_ANALOG_COMP] = req_en[SRC_ANALOG_COMP];
    pending[SRC_TWO_WIRE_SERIAL_UNIT] = req_en[SRC_TWO_WIRE_SERIAL_UNIT];
    pending[SRC_SELF_PROGRAM_STORE_DONE] = req_en[SRC_SELF_PROGRAM_STORE_DONE];
    if (!i_global_int_enable) begin
      pending = '0;
    end
    winner = lowest_pending(pending);
  end

  always_comb begin
    next_cur = cur;
    next_cur.reset_addr = i_boot_reset_select_fuse ? RESET_BASE : BOOT_START;
    next_cur.vec.valid = (winner != SRC_NONE) && !i_take;
    next_cur.vec.vector_no = (winner == SRC_NONE) ? 5'h00 : 5'(winner + 5'h02);
    next_cur.vec.addr = (winner == SRC_NONE) ? '0 : slot_addr(winner, i_vector_table_select);
    if (i_watchdog_int_flag_clear) begin
      next_cur.wdt.watchdog_int_flag = 1'b0;
    end
    if (i_watchdog_int_enable_clear) begin
      next_cur.wdt.watchdog_int_enable = 1'b0;
    end
    if (i_watchdog_int_enable_set) begin
      next_cur.wdt.watchdog_int_enable = 1'b1;
    end
    if (i_take && cur.vec.valid && cur.vec.vector_no == 5'(WDT_SRC_IDX + 5'h02)) begin
      next_cur.wdt.watchdog_int_flag = 1'b0;
      if (i_watchdog_reset_enable) begin
        next_cur.wdt.watchdog_int_enable = 1'b0;
      end
    end
    if (i_watchdog_timeout) begin
      next_cur.wdt.watchdog_int_flag = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cur <= '0;
      cur.reset_addr <= RESET_BASE;
    end else begin
      cur <= next_cur;
    end
  end

  always_comb begin
    o_reset_addr = cur.reset_addr;
    o_vec = cur.vec;
    o_watchdog_int_flag = cur.wdt.watchdog_int_flag;
    o_watchdog_int_enable = cur.wdt.watchdog_int_enable;
  end

endmodule

// ==== logic/vec_place_pkg.sv ====
// package for reset and interrupt vector placement
// shared by the vector placement module and its bench
package vec_place_pkg;
  localparam int NUM_SRC = 25;
  localparam int PC_W = 13;
  localparam logic [PC_W-1:0] RESET_BASE = 13'h0000;
  localparam logic [PC_W-1:0] IRQ_BASE_FIRST = 13'h0001;
  localparam logic [PC_W-1:0] BOOT_START_DEF = 13'h0C00;
  localparam logic [4:0] WDT_SRC_IDX = 5'h05;
  localparam logic [4:0] SRC_NONE = 5'h1F;

  // zero-based source indices, bit i of the request word
  localparam logic [4:0] SRC_EXT_IRQ_ZERO = 5'h00;
  localparam logic [4:0] SRC_EXT_IRQ_ONE = 5'h01;
  localparam logic [4:0] SRC_PIN_CHANGE_REQ_ZERO = 5'h02;
  localparam logic [4:0] SRC_PIN_CHANGE_REQ_ONE = 5'h03;
  localparam logic [4:0] SRC_PIN_CHANGE_REQ_TWO = 5'h04;
  localparam logic [4:0] SRC_TMR2_CMP_A = 5'h06;
  localparam logic [4:0] SRC_TMR2_CMP_B = 5'h07;
  localparam logic [4:0] SRC_TMR2_OVF = 5'h08;
  localparam logic [4:0] SRC_TMR1_CAPTURE = 5'h09;
  localparam logic [4:0] SRC_TMR1_CMP_A = 5'h0A;
  localparam logic [4:0] SRC_TMR1_CMP_B = 5'h0B;
  localparam logic [4:0] SRC_TMR1_OVF = 5'h0C;
  localparam logic [4:0] SRC_TMR0_CMP_A = 5'h0D;
  localparam logic [4:0] SRC_TMR0_CMP_B = 5'h0E;
  localparam logic [4:0] SRC_TMR0_OVF = 5'h0F;
  localparam logic [4:0] SRC_SPI_DONE = 5'h10;
  localparam logic [4:0] SRC_USART_RX_DONE = 5'h11;
  localparam logic [4:0] SRC_TX_BUFFER_EMPTY = 5'h12;
  localparam logic [4:0] SRC_USART_TX_DONE = 5'h13;
  localparam logic [4:0] SRC_ADC_DONE = 5'h14;
  localparam logic [4:0] SRC_EEPROM_WRITE_DONE = 5'h15;
  localparam logic [4:0] SRC_ANALOG_COMP = 5'h16;
  localparam logic [4:0] SRC_TWO_WIRE_SERIAL_UNIT = 5'h17;
  localparam logic [4:0] SRC_SELF_PROGRAM_STORE_DONE = 5'h18;

  // base-table addresses, one word spacing
  localparam logic [PC_W-1:0] BASE_EXT_IRQ_ZERO = IRQ_BASE_FIRST;
  localparam logic [PC_W-1:0] BASE_EXT_IRQ_ONE = 13'h0002;
  localparam logic [PC_W-1:0] BASE_PIN_CHANGE_REQ_ZERO = 13'h0003;
  localparam logic [PC_W-1:0] BASE_PIN_CHANGE_REQ_ONE = 13'h0004;
  localparam logic [PC_W-1:0] BASE_PIN_CHANGE_REQ_TWO = 13'h0005;
  localparam logic [PC_W-1:0] BASE_WDT = 13'h0006;
  localparam logic [PC_W-1:0] BASE_TMR2_CMP_A = 13'h0007;
  localparam logic [PC_W-1:0] BASE_TMR2_CMP_B = 13'h0008;
  localparam logic [PC_W-1:0] BASE_TMR2_OVF = 13'h0009;
  localparam logic [PC_W-1:0] BASE_TMR1_CAPTURE = 13'h000A;
  localparam logic [PC_W-1:0] BASE_TMR1_CMP_A = 13'h000B;
  localparam logic [PC_W-1:0] BASE_TMR1_CMP_B = 13'h000C;
  localparam logic [PC_W-1:0] BASE_TMR1_OVF = 13'h000D;
  localparam logic [PC_W-1:0] BASE_TMR0_CMP_A = 13'h000E;
  localparam logic [PC_W-1:0] BASE_TMR0_CMP_B = 13'h000F;
  localparam logic [PC_W-1:0] BASE_TMR0_OVF = 13'h0010;
  localparam logic [PC_W-1:0] BASE_SPI_DONE = 13'h0011;
  localparam logic [PC_W-1:0] BASE_USART_RX_DONE = 13'h0012;
  localparam logic [PC_W-1:0] BASE_TX_BUFFER_EMPTY = 13'h0013;
  localparam logic [PC_W-1:0] BASE_USART_TX_DONE = 13'h0014;
  localparam logic [PC_W-1:0] BASE_ADC_DONE = 13'h0015;
  localparam logic [PC_W-1:0] BASE_EEPROM_WRITE_DONE = 13'h0016;
  localparam logic [PC_W-1:0] BASE_ANALOG_COMP = 13'h0017;
  localparam logic [PC_W-1:0] BASE_TWO_WIRE_SERIAL_UNIT = 13'h0018;
  localparam logic [PC_W-1:0] BASE_SELF_PROGRAM_STORE_DONE = 13'h0019;

  typedef struct packed {
    logic valid;
    logic [PC_W-1:0] addr;
    logic [4:0] vector_no;
  } vec_req_t;

  typedef struct packed {
    logic watchdog_int_flag;
    logic watchdog_int_enable;
  } wdt_bits_t;
endpackage

// ==== testbench/core_model.sv ====
// fetch side model: takes every vector offered
// assumes the vector valid bit is registered on the rising edge
`timescale 1ns/1ps
module core_model (
  input wire logic i_sys_clk,
  input wire logic i_valid,
  output logic o_take
);
  // take is answered off the falling edge, one cycle per offer
  always @(negedge i_sys_clk) o_take <= i_valid;
endmodule

// ==== testbench/tb.sv ====
// bench for the vector placement block
// assumes the core model answers every offered vector
`timescale 1ns/1ps
module tb;
  import vec_place_pkg::*;
  logic clk = 0, rst = 1, fuse = 1, sel = 0, gie = 0, tmo = 0, wset = 0, take, wflag, wen;
  logic [NUM_SRC-1:0] req = '0;
  logic [NUM_SRC-1:0] en = '1;
  logic wde = 1;
  logic [PC_W-1:0] raddr;
  vec_req_t vec;
  int miscompares = 0, n_checks = 0;
  always #4 clk = ~clk;
  reset_irq_vector_placement i_reset_irq_vector_placement (.i_sys_clk(clk), .i_rst(rst),
    .i_boot_reset_select_fuse(fuse), .i_vector_table_select(sel), .i_global_int_enable(gie),
    .i_irq_req(req), .i_irq_en(en), .i_take(take), .i_watchdog_timeout(tmo),
    .i_watchdog_int_flag_clear(1'b0), .i_watchdog_int_enable_set(wset),
    .i_watchdog_int_enable_clear(1'b0), .i_watchdog_reset_enable(wde), .o_reset_addr(raddr),
    .o_vec(vec), .o_watchdog_int_flag(wflag), .o_watchdog_int_enable(wen));
  core_model i_core_model (.i_sys_clk(clk), .i_valid(vec.valid), .o_take(take));
  task chk(input string nm, input logic [17:0] exp, input logic [17:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task serve(input int i);
    repeat (10) begin
      @(negedge clk);
      if (vec.valid === 1'b1) break;
    end
    chk("vec", {PC_W'(i + 1) + (sel ? BOOT_START_DEF : 13'h0000), 5'(i + 2)},
      {vec.addr, vec.vector_no});
    req = '0;
    @(negedge clk);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst = 0;
    @(negedge clk) chk("reset addr", 18'(RESET_BASE), 18'(raddr));
    fuse = 0;
    @(negedge clk) chk("boot addr", 18'(BOOT_START_DEF), 18'(raddr));
    req = '1;
    repeat (3) @(negedge clk);
    chk("masked", 18'h0, 18'(vec.valid));
    gie = 1;
    en = '0;
    repeat (3) @(negedge clk);
    chk("disabled", 18'h0, 18'(vec.valid));
    en = '1;
    for (int k = 0; k < 50; k++) begin
      if (k % 25 == 5) continue;
      sel = k > 24;
      req = '1 << (k % 25);
      serve(k % 25);
    end
    wset = 1;
    tmo = 1;
    @(negedge clk) {wset, tmo} = 2'b00;
    serve(5);
    chk("wdt bits", 18'h0, {16'h0, wflag, wen});
    wde = 0;
    wset = 1;
    tmo = 1;
    @(negedge clk) {wset, tmo} = 2'b00;
    serve(5);
    chk("wdt int mode", 18'h1, {16'h0, wflag, wen});
    wrap_up;
  end
  initial begin
    #20000;
    miscompares++;
    wrap_up;
  end
endmodule

// ==== testbench/vec_place_assertions.sv ====
// checker for the vector placement block
// assumes a bind onto the placement module
`timescale 1ns/1ps
module vec_place_assertions
  import vec_place_pkg::*;
#(
  parameter int WORDS_PER_SLOT = 1,
  parameter logic [PC_W-1:0] BOOT_START = BOOT_START_DEF
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_boot_reset_select_fuse,
  input wire logic i_vector_table_select,
  input wire logic i_global_int_enable,
  input wire logic i_take,
  input wire logic i_watchdog_timeout,
  input wire logic i_watchdog_reset_enable,
  input wire logic [PC_W-1:0] o_reset_addr,
  input wire vec_req_t o_vec,
  input wire logic o_watchdog_int_flag,
  input wire logic o_watchdog_int_enable
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sequence s_wdt_taken;
    i_take && o_vec.valid && o_vec.vector_no == 5'h07 && !i_watchdog_timeout;
  endsequence
  a_reset_addr_app: assert property (
    i_boot_reset_select_fuse |=> o_reset_addr == RESET_BASE)
    else $error("reset address not zero");
  a_reset_addr_boot: assert property (
    !i_boot_reset_select_fuse |=> o_reset_addr == BOOT_START)
    else $error("reset address not boot start");
  a_global_mask: assert property (!i_global_int_enable |=> !o_vec.valid)
    else $error("vector offered while masked");
  a_take_drop: assert property (i_take |=> !o_vec.valid)
    else $error("vector held after take");
  a_vec_addr: assert property (o_vec.valid |->
    o_vec.addr == PC_W'((o_vec.vector_no - 1) * WORDS_PER_SLOT) +
    ($past(i_vector_table_select) ? BOOT_START : 13'h0000))
    else $error("vector address wrong");
  a_wdt_set: assert property (i_watchdog_timeout |=> o_watchdog_int_flag)
    else $error("timeout did not set flag");
  a_wdt_clear: assert property (s_wdt_taken |=> !o_watchdog_int_flag)
    else $error("flag kept after vector taken");
  a_wdt_combined: assert property (
    s_wdt_taken ##0 i_watchdog_reset_enable |=> !o_watchdog_int_enable)
    else $error("enable kept after vector taken in combined mode");
  a_vec_range: assert property (
    o_vec.valid |-> o_vec.vector_no inside {[5'h02:5'h1A]})
    else $error("vector number out of range");
endmodule
bind reset_irq_vector_placement vec_place_assertions #(
  .WORDS_PER_SLOT(WORDS_PER_SLOT),
  .BOOT_START(BOOT_START)
) i_vec_place_assertions (
  .i_sys_clk,
  .i_rst,
  .i_boot_reset_select_fuse,
  .i_vector_table_select,
  .i_global_int_enable,
  .i_take,
  .i_watchdog_timeout,
  .i_watchdog_reset_enable,
  .o_reset_addr,
  .o_vec,
  .o_watchdog_int_flag,
  .o_watchdog_int_enable
);
